/* design/ccif_capture.sv */
// Camera capture front end: pin sampling, timing decode, packing, output FIFOs.
// Assumes the memory-side writers drain the two word streams on the same clock.
`timescale 1ns/10ps
module ccif_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 8
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_flush,
  input wire logic i_valid,
  input wire logic [W-1:0] i_data,
  output logic o_ready,
  output logic o_valid,
  output logic [W-1:0] o_data,
  input wire logic i_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wp, rp, next_wp, next_rp;
  logic next_valid;
  logic [W-1:0] next_data;
  logic empty, wr, rd;
  always_comb begin
    empty = (wp == rp);
    o_ready = !((wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]));
    wr = i_valid && o_ready;
    rd = !empty && (!o_valid || i_ready);
    next_wp = wr ? wp + 1'b1 : wp;
    next_rp = rd ? rp + 1'b1 : rp;
    next_valid = rd ? 1'b1 : (o_valid && !i_ready);
    next_data = rd ? mem[rp[AW-1:0]] : o_data;
    if (i_flush) begin
      next_wp = '0;
      next_rp = '0;
      next_valid = 1'b0;
    end
  end
  always_ff @(posedge i_mclk) begin
    if (wr) begin
      mem[wp[AW-1:0]] <= i_data;
    end
  end
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      wp <= '0;
      rp <= '0;
      o_valid <= 1'b0;
      o_data <= '0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
      o_valid <= next_valid;
      o_data <= next_data;
    end
  end
endmodule

module ccif_capture #(
  parameter int DEPTH = ccif_pkg::FIFO_DEPTH,
  parameter int CLK_DIV = ccif_pkg::CAM_CLK_DIV
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_cam_pixel_clock_in,
  input wire logic i_cam_frame_sync_in,
  input wire logic i_cam_line_valid_in,
  input wire logic [7:0] i_cam_luma_data_in,
  input wire logic [7:0] i_cam_chroma_data_in,
  input wire logic i_capture_enable_global,
  input wire logic i_capture_enable_codec_scaler,
  input wire logic i_capture_enable_preview_scaler,
  input wire logic i_last_frame_irq_enable,
  input wire logic i_interface_soft_reset,
  input wire logic i_cam_reset_request,
  input wire logic i_itu601_mode,
  input wire logic i_in16bit,
  input wire logic [1:0] i_order,
  input wire logic [1:0] i_test_pattern,
  input wire logic i_inv_pclk,
  input wire logic i_inv_vsync,
  input wire logic i_inv_href,
  input wire logic i_codec_420,
  input wire logic i_preview_16bpp,
  input wire logic i_mirror_x,
  input wire logic i_mirror_y,
  input wire logic i_clr_ovf_codec,
  input wire logic i_clr_ovf_preview,
  input wire logic i_codec_ready,
  input wire logic i_preview_ready,
  output ccif_pkg::ccif_cword_t o_codec_word,
  output logic o_codec_valid,
  output logic [31:0] o_preview_word,
  output logic o_preview_valid,
  output logic [1:0] o_codec_buffer,
  output logic [1:0] o_preview_buffer,
  output logic o_mirror_x,
  output logic o_mirror_y,
  output logic o_frame_sync_status,
  output logic o_field,
  output logic o_frame_irq,
  output logic o_last_irq,
  output logic o_last_frame_irq_enable,
  output logic [1:0] o_frame_counter,
  output logic o_ovf_codec,
  output logic o_ovf_preview,
  output logic o_capturing,
  output logic o_cam_master_clock_out,
  output logic o_cam_reset_powerdown_out
);
  localparam int NP = ccif_pkg::NUM_PLANES;
  localparam int DW = ccif_pkg::DIM_W;

  function automatic logic [31:0] shift_in(input logic [31:0] w, input logic [7:0] b);
    shift_in = {b, w[31:8]};
  endfunction

  function automatic logic [15:0] gray565(input logic [7:0] y);
    gray565 = {y[7:3], y[7:2], y[7:3]};
  endfunction

  ccif_pkg::ccif_pins_t s1, s2, pins;
  logic pclk3;
  ccif_pkg::ccif_sync_st_t st, next_st;
  logic fs_q, hr_q, line_on, v656, cap_c, cap_p, armed, c420, p16, pp, ppv;
  logic next_fs, next_hr, next_line_on, next_v656, next_field, next_cap_g, next_cap_c;
  logic next_cap_p, next_armed, next_c420, next_p16, next_mx, next_my, next_irq, next_lirq;
  logic next_pp, next_ppv, next_ovf_c, next_ovf_p, next_camclk;
  logic [1:0] next_fcnt, next_cbuf, next_pbuf;
  logic [DW-1:0] hpix, vcnt, next_hpix, next_vcnt, lim;
  logic phase, cphase, next_phase, next_cphase;
  logic [31:0] sh [NP], pend [NP], next_sh [NP], next_pend [NP];
  logic [1:0] cnt [NP], next_cnt [NP];
  logic [NP-1:0] pv, next_pv;
  logic [31:0] pw, ppend, next_pw, next_ppend, pword;
  logic [7:0] lb, ybyte, cbyte;
  logic [1:0] cplane, sel;
  logic [7:0] div, next_div;
  logic pedge, fsync, hr, fs_fall, act, samp, y_ev, c_ev, is_y, xy_hit, line_end;
  logic c_push, p_push, c_rdy, p_rdy, pdone;
  ccif_pkg::ccif_cword_t c_in;

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      s1 <= '0;
      s2 <= '0;
      pclk3 <= 1'b0;
    end else begin
      s1 <= {i_cam_pixel_clock_in, i_cam_frame_sync_in, i_cam_line_valid_in,
             i_cam_luma_data_in, i_cam_chroma_data_in};
      s2 <= s1;
      pclk3 <= s2.pclk;
    end
  end

  always_comb begin
    pins = s2;
    pedge = ((pins.pclk ^ i_inv_pclk) && !(pclk3 ^ i_inv_pclk)); // see R11 see R17
    hr = pins.lval ^ i_inv_href; // see R17
    fsync = i_itu601_mode ? (pins.fsync ^ i_inv_vsync) : v656; // see R4
    fs_fall = fs_q && !fsync;
    lb = pins.luma;
    next_fs = fsync;
    next_hr = hr;
    next_st = st;
    next_line_on = line_on;
    next_v656 = v656;
    next_field = o_field;
    xy_hit = 1'b0;
    if (pedge) begin
      unique case (st) // see R6
        ccif_pkg::SC_IDLE: next_st = (lb == ccif_pkg::PRE_ONES) ? ccif_pkg::SC_ONES : st;
        ccif_pkg::SC_ONES: next_st = (lb == ccif_pkg::PRE_ZERO) ? ccif_pkg::SC_ZERO1 :
                                     (lb == ccif_pkg::PRE_ONES) ? st : ccif_pkg::SC_IDLE;
        ccif_pkg::SC_ZERO1: next_st = (lb == ccif_pkg::PRE_ZERO) ? ccif_pkg::SC_ZERO2 :
                                      ccif_pkg::SC_IDLE;
        ccif_pkg::SC_ZERO2: begin
          next_st = ccif_pkg::SC_IDLE;
          xy_hit = lb[ccif_pkg::XY_ONE]; // see R2
        end
      endcase
    end
    if (xy_hit) begin
      next_field = lb[ccif_pkg::XY_F]; // see R3
      next_v656 = lb[ccif_pkg::XY_V]; // see R4
      next_line_on = !lb[ccif_pkg::XY_H] && !lb[ccif_pkg::XY_V]; // see R5
    end
    // Reserved FF/00 values never occur as video, so code bytes are skipped
    act = i_itu601_mode ? hr :
          (line_on && st == ccif_pkg::SC_IDLE && lb != ccif_pkg::PRE_ONES); // see R5
    line_end = i_itu601_mode ? (hr_q && !hr) : (xy_hit && line_on && lb[ccif_pkg::XY_H]);
    lim = (cap_c || cap_p) ? ccif_pkg::MAX_DIM_SCALED : ccif_pkg::MAX_DIM;
    samp = pedge && o_capturing && act && hpix < lim && vcnt < lim; // see R1
    is_y = i_in16bit || (phase == i_order[1]); // see R7 see R8
    unique case (i_test_pattern) // see R17
      ccif_pkg::TP_NONE: ybyte = lb;
      ccif_pkg::TP_BAR: ybyte = {hpix[9:7], 5'h00};
      ccif_pkg::TP_HINC: ybyte = hpix[7:0];
      default: ybyte = vcnt[7:0];
    endcase
    cbyte = i_in16bit ? pins.chroma : ybyte; // see R7 see R8
    cplane = (cphase ^ i_order[0]) ? ccif_pkg::PL_CR : ccif_pkg::PL_CB;
    y_ev = samp && is_y;
    c_ev = samp && (i_in16bit || !is_y) && !(c420 && vcnt[0]); // see R10
    next_phase = samp ? !phase : phase;
    next_cphase = (samp && (i_in16bit || !is_y)) ? !cphase : cphase;
    next_hpix = y_ev ? hpix + 1'b1 : hpix;
    next_vcnt = vcnt;
    if (line_end) begin
      next_hpix = '0;
      next_phase = 1'b0;
      next_cphase = 1'b0;
      next_vcnt = (vcnt < lim) ? vcnt + 1'b1 : vcnt;
    end
    next_cap_g = o_capturing;
    next_cap_c = cap_c;
    next_cap_p = cap_p;
    next_armed = armed;
    next_c420 = c420;
    next_p16 = p16;
    next_mx = o_mirror_x;
    next_my = o_mirror_y;
    next_irq = 1'b0;
    next_lirq = 1'b0;
    next_cbuf = o_codec_buffer;
    next_pbuf = o_preview_buffer;
    if (fs_fall) begin // see R18
      next_cap_g = i_capture_enable_global;
      next_cap_c = i_capture_enable_global && i_capture_enable_codec_scaler; // see R9
      next_cap_p = i_capture_enable_global && i_capture_enable_preview_scaler; // see R9
      next_c420 = i_codec_420;
      next_p16 = i_preview_16bpp;
      next_mx = i_mirror_x; // see R16
      next_my = i_mirror_y; // see R16
      next_irq = i_capture_enable_global; // see R21
      next_lirq = armed && o_capturing && !i_capture_enable_global; // see R21
      next_armed = next_lirq ? 1'b0 : i_last_frame_irq_enable; // see R21
      next_vcnt = '0;
      next_hpix = '0;
      next_cbuf = cap_c ? o_codec_buffer + 1'b1 : o_codec_buffer; // see R13
      next_pbuf = cap_p ? o_preview_buffer + 1'b1 : o_preview_buffer; // see R13
    end
    next_fcnt = (next_irq || next_lirq) ? o_frame_counter + 1'b1 : o_frame_counter; // see R22
    sel = pv[0] ? ccif_pkg::PL_Y : (pv[1] ? ccif_pkg::PL_CB : ccif_pkg::PL_CR);
    c_in = '{plane: sel, data: pend[sel]};
    c_push = |pv && c_rdy; // see R23
    next_ovf_c = o_ovf_codec && !i_clr_ovf_codec; // see R24
    next_ovf_p = o_ovf_preview && !i_clr_ovf_preview; // see R24
    if (y_ev && cap_p && !cap_c) begin
      next_ovf_c = 1'b1; // see R20
    end
    next_pv = pv;
    if (c_push) begin
      next_pv[sel] = 1'b0;
    end
    for (int p = 0; p < NP; p++) begin
      next_sh[p] = sh[p];
      next_cnt[p] = cnt[p];
      next_pend[p] = pend[p];
      if (cap_c && (p == 0 ? y_ev : (c_ev && cplane == 2'(p)))) begin // see R10
        next_sh[p] = shift_in(sh[p], p == 0 ? ybyte : cbyte); // see R14
        next_cnt[p] = cnt[p] + 1'b1;
        if (cnt[p] == ccif_pkg::BYTE_LAST) begin
          if (next_pv[p]) begin
            next_ovf_c = 1'b1; // see R23
          end else begin
            next_pv[p] = 1'b1;
            next_pend[p] = next_sh[p];
          end
        end
      end
    end
    p_push = ppv && p_rdy;
    next_ppv = ppv && !p_push;
    next_ppend = ppend;
    next_pw = pw;
    next_pp = pp;
    pdone = 1'b0;
    pword = {8'h00, ybyte, ybyte, ybyte}; // see R15
    if (y_ev && cap_p) begin
      if (!p16) begin
        pdone = 1'b1;
      end else if (!pp) begin
        next_pw = {16'h0000, gray565(ybyte)}; // see R15
        next_pp = 1'b1;
      end else begin
        pword = {gray565(ybyte), pw[15:0]};
        next_pp = 1'b0;
        pdone = 1'b1;
      end
    end
    if (pdone) begin
      if (next_ppv) begin
        next_ovf_p = 1'b1; // see R23
      end else begin
        next_ppv = 1'b1;
        next_ppend = pword;
      end
    end
    if (i_interface_soft_reset) begin
      next_cap_g = 1'b0;
      next_cap_c = 1'b0;
      next_cap_p = 1'b0;
      next_armed = 1'b0;
      next_pv = '0;
      next_ppv = 1'b0;
      next_pp = 1'b0;
      for (int p = 0; p < NP; p++) begin
        next_cnt[p] = '0;
      end
    end
    next_div = (div == 8'(CLK_DIV - 1)) ? 8'h00 : div + 8'h01;
    next_camclk = (div == 8'(CLK_DIV - 1)) ? !o_cam_master_clock_out : o_cam_master_clock_out;
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      st <= ccif_pkg::SC_IDLE;
      {fs_q, hr_q, line_on, v656, o_field} <= '0;
      {o_capturing, cap_c, cap_p, armed, c420, p16, o_mirror_x, o_mirror_y} <= '0;
      {o_frame_irq, o_last_irq, o_ovf_codec, o_ovf_preview} <= '0;
      {o_frame_counter, o_codec_buffer, o_preview_buffer} <= '0;
      {hpix, vcnt, phase, cphase, pv, ppv, pp, pw, ppend} <= '0;
      for (int p = 0; p < NP; p++) begin
        sh[p] <= '0;
        pend[p] <= '0;
        cnt[p] <= '0;
      end
      div <= 8'h00;
      o_cam_master_clock_out <= 1'b0;
      o_cam_reset_powerdown_out <= 1'b0;
    end else begin
      st <= next_st;
      {fs_q, hr_q, line_on, v656, o_field} <= {next_fs, next_hr, next_line_on, next_v656,
                                               next_field};
      {o_capturing, cap_c, cap_p, armed} <= {next_cap_g, next_cap_c, next_cap_p, next_armed};
      {c420, p16, o_mirror_x, o_mirror_y} <= {next_c420, next_p16, next_mx, next_my};
      {o_frame_irq, o_last_irq, o_ovf_codec, o_ovf_preview} <= {next_irq, next_lirq,
                                                                next_ovf_c, next_ovf_p};
      {o_frame_counter, o_codec_buffer, o_preview_buffer} <= {next_fcnt, next_cbuf, next_pbuf};
      {hpix, vcnt, phase, cphase} <= {next_hpix, next_vcnt, next_phase, next_cphase};
      {pv, ppv, pp, pw, ppend} <= {next_pv, next_ppv, next_pp, next_pw, next_ppend};
      sh <= next_sh;
      pend <= next_pend;
      cnt <= next_cnt;
      div <= next_div;
      o_cam_master_clock_out <= next_camclk;
      o_cam_reset_powerdown_out <= i_cam_reset_request;
    end
  end

  assign o_frame_sync_status = fs_q; // see R18
  assign o_last_frame_irq_enable = armed;

  ccif_fifo #(.W($bits(ccif_pkg::ccif_cword_t)), .DEPTH(DEPTH)) u_codec_fifo (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_flush(i_interface_soft_reset),
    .i_valid(|pv), .i_data(c_in), .o_ready(c_rdy),
    .o_valid(o_codec_valid), .o_data(o_codec_word), .i_ready(i_codec_ready));

  ccif_fifo #(.W(32), .DEPTH(DEPTH)) u_preview_fifo (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_flush(i_interface_soft_reset),
    .i_valid(ppv), .i_data(ppend), .o_ready(p_rdy),
    .o_valid(o_preview_valid), .o_data(o_preview_word), .i_ready(i_preview_ready));

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  a_cmd_at_sync: assert property (fs_fall |=> o_capturing == $past(i_capture_enable_global)
    && o_mirror_x == $past(i_mirror_x)) else $error("command not taken at sync fall"); // see R18
  a_count_step: assert property ((o_frame_irq || o_last_irq) |->
    o_frame_counter == $past(o_frame_counter) + 2'h1) else $error("counter not stepped"); // see R22
  a_last_autoclr: assert property (o_last_irq |-> !armed && !o_capturing)
    else $error("last enable not cleared"); // see R21
  a_ovf_sticky: assert property (o_ovf_codec && !i_clr_ovf_codec |=> o_ovf_codec)
    else $error("codec overflow dropped"); // see R24
  a_codec_idle: assert property (y_ev && cap_p && !cap_c && !i_interface_soft_reset
    |=> o_ovf_codec) else $error("idle codec overflow missing"); // see R20
  a_pack_order: assert property (cap_c && y_ev |=> sh[0][31:24] == $past(ybyte))
    else $error("latest byte not in top lane"); // see R14
  a_size_limit: assert property (hpix <= lim && vcnt <= lim)
    else $error("pixel counter beyond size limit"); // see R1
  a_v_flag: assert property (xy_hit |=> v656 == $past(lb[ccif_pkg::XY_V]))
    else $error("vertical flag not decoded"); // see R4
  a_luma_only: assert property (samp && !i_in16bit |-> cbyte == ybyte)
    else $error("chroma lines used in 8-bit mode"); // see R7
  a_rgb24_word: assert property (pdone && !p16 |-> pword[31:24] == 8'h00)
    else $error("24-bit preview word malformed"); // see R15
  c_frame_irq: cover property (o_frame_irq);
  c_last_irq: cover property (o_last_irq);
  c_codec_push: cover property (c_push && sel == ccif_pkg::PL_CR);
  c_preview_pair: cover property (pdone && p16);
endmodule

/* design/ccif_pkg.sv */
// Constants and carriers for the camera capture front end.
// Assumes a single system clock; camera pins are sampled, never used as clocks.
// Behaviour
// R1 - Accept frames up to 4096x4096, or 2048x2048 while a scaler is enabled.
// R2 - Fourth timing-code byte holds fixed one, F, V, H flags, then protection bits.
// R3 - Field flag decodes 0 as first field, 1 as second field.
// R4 - Vertical flag is 1 in field blanking and serves as frame sync.
// R5 - Horizontal flag 0 starts active video, 1 ends it; pixels lie between.
// R6 - Timing code recognised only after FF-00-00 preamble; flags from next byte.
// R7 - 8-bit mode takes Y, Cb, Cr from luma lines only; chroma lines ignored.
// R8 - 16-bit mode takes luma and chroma lines in the same pixel cycle.
// R9 - Preview and codec output ports run independently; each can be disabled.
// R10 - Codec port writes planar YCbCr 4:2:0 or 4:2:2; preview writes RGB.
// R11 - Pixel clock unrelated to system clock; processing runs on system clock.
// R12 - Integrator keeps system clock faster than pixel clock.
// R13 - Each port rotates four buffers; codec buffers have Y, Cb, Cr planes.
// R14 - Codec words packed little-endian: earliest sample in lowest byte.
// R15 - Preview stores one 24-bit pixel or two 16-bit pixels per word.
// R16 - Outputs can mirror about X or Y, or rotate 180 degrees.
// R17 - Sync and pixel clock polarity invertible; internal test pattern source.
// R18 - Commands take effect at frame sync fall; sync level readable.
// R19 - Software keeps target size fixed during capture.
// R20 - Codec overflow set when preview runs with codec idle; software recovers.
// R21 - Frame interrupt before each capture; last interrupt at end, enable auto-cleared.
// R22 - Frame counter steps by one at each interrupt, cycling 0 to 3.
// R23 - Data crosses to the output side through a FIFO; overflow flagged when full.
// R24 - Overflow flags stay set until their clear control is asserted.
package ccif_pkg;
  localparam int DIM_W = 13;
  localparam logic [DIM_W-1:0] MAX_DIM = 13'h1000;
  localparam logic [DIM_W-1:0] MAX_DIM_SCALED = 13'h0800;
  localparam logic [7:0] PRE_ONES = 8'hff;
  localparam logic [7:0] PRE_ZERO = 8'h00;
  localparam int XY_ONE = 7;
  localparam int XY_F = 6;
  localparam int XY_V = 5;
  localparam int XY_H = 4;
  localparam logic [1:0] TP_NONE = 2'h0;
  localparam logic [1:0] TP_BAR = 2'h1;
  localparam logic [1:0] TP_HINC = 2'h2;
  localparam logic [1:0] PL_Y = 2'h0;
  localparam logic [1:0] PL_CB = 2'h1;
  localparam logic [1:0] PL_CR = 2'h2;
  localparam int NUM_PLANES = 3;
  localparam logic [1:0] BYTE_LAST = 2'h3;
  localparam int FIFO_DEPTH = 8;
  localparam int CAM_CLK_DIV = 2;
  typedef struct packed {
    logic pclk;
    logic fsync;
    logic lval;
    logic [7:0] luma;
    logic [7:0] chroma;
  } ccif_pins_t;
  typedef struct packed {
    logic [1:0] plane;
    logic [31:0] data;
  } ccif_cword_t;
  typedef enum logic [1:0] {
    SC_IDLE = 2'b00,
    SC_ONES = 2'b01,
    SC_ZERO1 = 2'b11,
    SC_ZERO2 = 2'b10
  } ccif_sync_st_t;
endpackage

/* sim/ccif_cam_model.sv */
// Behavioural camera source: pixel clock, syncs, luma and chroma lines.
// Assumes a capture clock at least eight times faster than the pixel clock.
`timescale 1ns/10ps
module ccif_cam_model (
  input wire logic i_inv,
  output logic o_pclk,
  output logic o_fsync,
  output logic o_lval,
  output logic [7:0] o_luma,
  output logic [7:0] o_chroma
);
  logic pc = 1'b0;
  logic fs = 1'b1;
  logic lv = 1'b0;
  logic [7:0] y = 8'h5a;
  logic [7:0] c = 8'ha5;
  assign o_pclk = pc ^ i_inv;
  assign o_fsync = fs ^ i_inv;
  assign o_lval = lv ^ i_inv;
  assign o_luma = y;
  assign o_chroma = c;
  // Pixel clock idles low between frames; data moves only while it is low
  task automatic tick;
    #400 pc = 1'b1;
    #400 pc = 1'b0;
  endtask
  task automatic send(input logic [7:0] b);
    y = b;
    c = ~c;
    tick();
  endtask
  task automatic code(input logic f, input logic v, input logic h);
    for (int i = 0; i < 3; i++) send(i == 0 ? 8'hff : 8'h00);
    send({1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h});
  endtask
  // Modes: 0 sync pins 8-bit, 1 sync pins 16-bit, 2 embedded codes
  task automatic frame(input int mode, input int lines, input logic [7:0] base, input logic f);
    #10;
    if (mode == 2) code(f, 1'b1, 1'b1);
    else begin
      fs = 1'b1;
      send(~y);
      fs = 1'b0;
      send(~y);
    end
    for (int l = 0; l < lines; l++) begin
      if (mode == 2) code(f, 1'b0, 1'b0);
      lv = mode != 2;
      for (int i = 0; i < 16; i++) begin
        y = base + 8'(l * 16 + i);
        c = mode == 1 ? y + 8'h80 : ~c;
        tick();
      end
      lv = 1'b0;
      if (mode == 2) code(f, 1'b0, 1'b1);
      else repeat (2) send(~y);
    end
    if (mode == 2) code(f, 1'b1, 1'b1);
    fs = 1'b1;
    send(~y);
  endtask
endmodule

/* sim/ccif_capture_bench.sv */
// Self-checking bench for the camera capture front end.
// Assumes default FIFO depth and divider; camera side is a behavioural model.
`timescale 1ns/10ps
module ccif_capture_bench;
  logic i_mclk = 1'b0;
  logic i_reset = 1'b1;
  logic en_g = 1'b0, en_c = 1'b0, en_p = 1'b0, last_en = 1'b0, srst = 1'b0, cam_rst = 1'b0;
  logic m601 = 1'b0, in16 = 1'b0, inv = 1'b1, mx = 1'b0, my = 1'b0, clr = 1'b0;
  logic c_rdy = 1'b0, p_rdy = 1'b0, hold = 1'b0;
  logic c420 = 1'b0, p16 = 1'b0;
  logic [1:0] ord = 2'h0;
  wire pclk, fsync, lval;
  wire [7:0] luma, chroma;
  ccif_pkg::ccif_cword_t cw;
  logic cv, pv, mxo, myo, fss, fld, firq, lirq, lie, ovc, ovp, capt, mco, rpo;
  logic [31:0] pw;
  logic [1:0] cbuf, pbuf, fcnt, b0;
  logic [31:0] lfsr = 32'h4d85;
  int errors = 0, tests_run = 0, cycles = 0, nfi = 0, nli = 0;
  logic [7:0] gy[$], gb[$], gr[$], ey[$], eb[$], er[$];
  logic [31:0] gp[$];

  ccif_cam_model ccif_cam_model_i (.i_inv(inv), .o_pclk(pclk), .o_fsync(fsync), .o_lval(lval),
    .o_luma(luma), .o_chroma(chroma));
  ccif_capture ccif_capture_i (.i_mclk(i_mclk), .i_reset(i_reset),
    .i_cam_pixel_clock_in(pclk), .i_cam_frame_sync_in(fsync), .i_cam_line_valid_in(lval),
    .i_cam_luma_data_in(luma), .i_cam_chroma_data_in(chroma),
    .i_capture_enable_global(en_g), .i_capture_enable_codec_scaler(en_c),
    .i_capture_enable_preview_scaler(en_p), .i_last_frame_irq_enable(last_en),
    .i_interface_soft_reset(srst), .i_cam_reset_request(cam_rst), .i_itu601_mode(m601),
    .i_in16bit(in16), .i_order(ord), .i_test_pattern(2'h0), .i_inv_pclk(inv),
    .i_inv_vsync(inv), .i_inv_href(inv), .i_codec_420(c420), .i_preview_16bpp(p16),
    .i_mirror_x(mx), .i_mirror_y(my), .i_clr_ovf_codec(clr), .i_clr_ovf_preview(clr),
    .i_codec_ready(c_rdy), .i_preview_ready(p_rdy), .o_codec_word(cw), .o_codec_valid(cv),
    .o_preview_word(pw), .o_preview_valid(pv), .o_codec_buffer(cbuf), .o_preview_buffer(pbuf),
    .o_mirror_x(mxo), .o_mirror_y(myo), .o_frame_sync_status(fss), .o_field(fld),
    .o_frame_irq(firq), .o_last_irq(lirq), .o_last_frame_irq_enable(lie),
    .o_frame_counter(fcnt), .o_ovf_codec(ovc), .o_ovf_preview(ovp), .o_capturing(capt),
    .o_cam_master_clock_out(mco), .o_cam_reset_powerdown_out(rpo));

  always #50 i_mclk = ~i_mclk;

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
  endfunction

  function automatic logic [15:0] rgb565(input logic [7:0] y);
    return {y[7:3], y[7:2], y[7:3]};
  endfunction

  task automatic test_done;
    $display("Checks %0d, errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Sinks stall at random so the output FIFOs really fill and drain
  always @(posedge i_mclk) begin
    lfsr <= nxt(lfsr);
    c_rdy <= ~hold & lfsr[0];
    p_rdy <= lfsr[1] | lfsr[2];
    cycles <= cycles + 1;
    if (cv === 1'b1 && c_rdy === 1'b1) begin
      for (int b = 0; b < 4; b++) begin
        if (cw.plane === ccif_pkg::PL_Y) gy.push_back(cw.data[8*b +: 8]);
        else if (cw.plane === ccif_pkg::PL_CB) gb.push_back(cw.data[8*b +: 8]);
        else gr.push_back(cw.data[8*b +: 8]);
      end
    end
    if (pv === 1'b1 && p_rdy === 1'b1) gp.push_back(pw);
    if (firq === 1'b1) nfi <= nfi + 1;
    if (lirq === 1'b1) nli <= nli + 1;
    if (cycles > 30000) begin
      errors++;
      test_done();
    end
  end

  // Byte k of a frame is base+k; in 8-bit mode ord[1] puts chroma first
  task automatic expect_frame(input int mode, input int lines, input logic [7:0] base);
    logic [7:0] v;
    int j;
    for (int k = 0; k < lines * 16; k++) begin
      v = base + 8'(k);
      j = mode == 1 ? k : k / 2;
      if (mode == 1 || (k % 2 == 1) == ord[1]) ey.push_back(v);
      if ((mode == 1 || (k % 2 == 0) == ord[1]) && !(c420 && k / 16 % 2 == 1)) begin
        if ((j % 2 == 1) == ord[0]) eb.push_back(mode == 1 ? v + 8'h80 : v);
        else er.push_back(mode == 1 ? v + 8'h80 : v);
      end
    end
  endtask

  task automatic check_q(input logic prev);
    int n;
    int np;
    n = 0;
    np = p16 ? ey.size() / 2 : ey.size();
    while (n < 600 && (prev ? gp.size() < np : (gy.size() < ey.size() ||
        gb.size() < eb.size() || gr.size() < er.size()))) begin
      @(posedge i_mclk);
      n++;
    end
    if (prev) begin
      cmp(32'(gp.size()), 32'(np));
      foreach (gp[i]) if (i < np) cmp(gp[i], p16 ? {rgb565(ey[2*i+1]), rgb565(ey[2*i])} :
          {8'h00, ey[i], ey[i], ey[i]});
    end else begin
      cmp(32'(gy.size()), 32'(ey.size()));
      cmp(32'(gb.size()), 32'(eb.size()));
      cmp(32'(gr.size()), 32'(er.size()));
      foreach (gy[i]) if (i < ey.size()) cmp({24'h0, gy[i]}, {24'h0, ey[i]});
      foreach (gb[i]) if (i < eb.size()) cmp({24'h0, gb[i]}, {24'h0, eb[i]});
      foreach (gr[i]) if (i < er.size()) cmp({24'h0, gr[i]}, {24'h0, er[i]});
    end
    gy.delete();
    gb.delete();
    gr.delete();
    gp.delete();
    ey.delete();
    eb.delete();
    er.delete();
  endtask

  task automatic run(input int mode, input int lines, input logic cap);
    logic [7:0] base;
    logic f;
    base = 8'h10 + {3'h0, lfsr[4:0]};
    f = lfsr[5];
    @(posedge i_mclk);
    if (cap) expect_frame(mode, lines, base);
    ccif_cam_model_i.frame(mode, lines, base, f);
    repeat (8) @(posedge i_mclk);
    if (mode == 2) cmp(32'(fld), 32'(f));
    cmp({30'h0, fcnt}, {30'h0, 2'(nfi + nli)});
  endtask

  initial begin
    repeat (16) @(posedge i_mclk);
    i_reset <= 1'b0;
    repeat (4) @(posedge i_mclk);
    en_g <= 1'b1;
    en_c <= 1'b1;
    cam_rst <= 1'b1;
    repeat (3) @(posedge i_mclk);
    cmp(32'(capt), 32'h0);
    cmp(32'(rpo), 32'h1);
    // Polarity is switched while embedded codes rule, so no false sync edge
    for (int k = 0; k < 3; k++) begin
      if (k == 1) begin
        inv <= 1'b0;
        repeat (4) @(posedge i_mclk);
        b0 = cbuf;
      end
      m601 <= k != 0;
      in16 <= k == 2;
      c420 <= k == 1;
      ord <= lfsr[10:9];
      mx <= lfsr[6];
      my <= lfsr[7];
      run((k + 2) % 3, 2, 1'b1);
      check_q(1'b0);
      cmp(32'(nfi), 32'(k + 1));
      cmp({30'h0, mxo, myo}, {30'h0, mx, my});
      cmp(32'(fss), 32'h1);
    end
    cmp({30'h0, cbuf}, {30'h0, 2'(b0 + 2'h2)});
    in16 <= 1'b0;
    last_en <= 1'b1;
    run(0, 2, 1'b1);
    check_q(1'b0);
    cmp(32'(lie), 32'h1);
    last_en <= 1'b0;
    en_g <= 1'b0;
    en_c <= 1'b0;
    run(0, 1, 1'b0);
    check_q(1'b0);
    cmp(32'(nli), 32'h1);
    cmp(32'(lie), 32'h0);
    en_g <= 1'b1;
    en_p <= 1'b1;
    for (int j = 0; j < 2; j++) begin
      p16 <= j == 1;
      run(0, 2, 1'b1);
      check_q(1'b1);
    end
    cmp(32'(ovc), 32'h1);
    en_g <= 1'b0;
    en_p <= 1'b0;
    srst <= 1'b1;
    @(posedge i_mclk);
    srst <= 1'b0;
    repeat (2) @(posedge i_mclk);
    cmp({30'h0, ovc, capt}, 32'h2);
    clr <= 1'b1;
    @(posedge i_mclk);
    clr <= 1'b0;
    repeat (2) @(posedge i_mclk);
    cmp(32'(ovc), 32'h0);
    en_g <= 1'b1;
    en_c <= 1'b1;
    hold <= 1'b1;
    run(0, 4, 1'b0);
    cmp(32'(ovc), 32'h1);
    hold <= 1'b0;
    repeat (60) @(posedge i_mclk);
    cmp(32'(ovc), 32'h1);
    clr <= 1'b1;
    @(posedge i_mclk);
    clr <= 1'b0;
    repeat (2) @(posedge i_mclk);
    cmp({30'h0, ovc, ovp}, 32'h0);
    test_done();
  end
endmodule
